//--- shared/tws_pkg.sv
// shared constants for the two-wire eeprom device and its bus host
package tws_pkg;
   localparam int          CLK_HZ     = 40_000_000;
   localparam int          T_PROG_US  = 5000;
   localparam int          PROG_CYC   = T_PROG_US * (CLK_HZ / 1_000_000);
   localparam int          SCL_QUART  = 5;
   localparam logic [3:0]  TYPE_CODE  = 4'ha;
   localparam int          PAGE_BYTES = 16;
   localparam int          MEM_BYTES  = 256;
   localparam int          COL_W      = 4;
   localparam logic [3:0]  BIT_ACK    = 4'h8;
   localparam logic [3:0]  BIT_DONE   = 4'h9;
   localparam logic [7:0]  PTR_RST    = 8'h00;
   localparam int          AXI_AW     = 8;
   localparam logic [7:0]  REG_CMD    = 8'h00;
   localparam logic [7:0]  REG_STAT   = 8'h04;
   localparam int          CMD_TX_LSB = 0;
   localparam int          CMD_OP_LSB = 8;
   localparam int          CMD_NACK   = 11;
   localparam int          STAT_BUSY  = 0;
   localparam int          STAT_ACK   = 1;
   localparam int          STAT_RX    = 8;
   localparam logic [2:0]  OP_START   = 3'h1;
   localparam logic [2:0]  OP_STOP    = 3'h2;
   localparam logic [2:0]  OP_WRITE   = 3'h3;
   localparam logic [2:0]  OP_READ    = 3'h4;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLV   = 2'h2;
endpackage

//--- shared/tws_if.sv
// two-wire bus carrier joining the host end and the device end
`timescale 1ns/1ps
`default_nettype none
interface tws_if;
   logic scl;
   logic sda;
   logic m_sda_o;
   logic m_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   // wired-and with an implied pull-up
   assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));
   modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
   modport host (output scl, input sda, output m_sda_o, output m_sda_oe);
endinterface
`default_nettype wire

//--- src/tws_eeprom_dev.sv
// two-wire serial eeprom device end with 256-byte array
`timescale 1ns/1ps
`default_nettype none
module tws_eeprom_dev #(
   parameter int PROG_CYCLES = tws_pkg::PROG_CYC
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   tws_if.dev        bus,
   input  wire logic chip_select_bit_high,
   input  wire logic chip_select_bit_mid,
   input  wire logic chip_select_bit_low,
   input  wire logic write_protect,
   output logic      standby,
   output logic      prog_busy
);
   import tws_pkg::*;

   localparam int BW = $clog2(PROG_CYCLES + 1);

   typedef enum logic [2:0] {S_IDLE, S_DEV, S_WADR, S_WDAT, S_RD} tws_st_e;

   tws_st_e                st;
   tws_st_e                next_st;
   logic [3:0]             cnt;
   logic [3:0]             next_cnt;
   logic [7:0]             sh;
   logic [7:0]             next_sh;
   logic                   oe;
   logic                   next_oe;
   logic [7:0]             ptr;
   logic [7:0]             next_ptr;
   logic                   pend;
   logic                   next_pend;
   logic [PAGE_BYTES-1:0]  pval;
   logic [PAGE_BYTES-1:0]  next_pval;
   logic [7:0]             pbuf [PAGE_BYTES];
   logic [7:0]             next_pbuf [PAGE_BYTES];
   logic [BW-1:0]          busy;
   logic [BW-1:0]          next_busy;
   logic [7:0]             mem [MEM_BYTES];
   logic [7:0]             next_mem [MEM_BYTES];
   logic                   do_commit;
   logic [2:0]             scl_q;
   logic [2:0]             sda_q;
   logic [3:0]             pin_q1;
   logic [3:0]             pin_q2;
   logic                   scl_rise;
   logic                   scl_fall;
   logic                   start_c;
   logic                   stop_c;
   logic                   sda_s;
   logic                   wp_s;
   logic [2:0]             cs_s;
   logic [7:0]             rd_byte;

   // two stages before any logic; the third stage only remembers the last level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_q  <= 3'h7;
         sda_q  <= 3'h7;
         pin_q1 <= 4'h0;
         pin_q2 <= 4'h0;
      end else begin
         scl_q  <= {scl_q[1:0], bus.scl};
         sda_q  <= {sda_q[1:0], bus.sda};
         pin_q1 <= {write_protect, chip_select_bit_high, chip_select_bit_mid, chip_select_bit_low};
         pin_q2 <= pin_q1;
      end
   end

   assign scl_rise = scl_q[1] && !scl_q[2];
   assign scl_fall = !scl_q[1] && scl_q[2];
   assign start_c  = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1];
   assign stop_c   = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1];
   assign sda_s    = sda_q[1];
   // the bench drives every select pin, so none is left floating
   assign cs_s     = pin_q2[2:0];
   assign wp_s     = pin_q2[3];
   assign rd_byte  = mem[ptr];

   always_comb begin
      next_st   = st;
      next_cnt  = cnt;
      next_sh   = sh;
      next_oe   = oe;
      next_ptr  = ptr;
      next_pend = pend;
      next_pval = pval;
      next_pbuf = pbuf;
      next_busy = busy;
      do_commit = 1'b0;
      if (busy != '0) begin
         next_busy = busy - 1'b1;
      end
      if (start_c) begin
         // a new start also drops any page loaded but not yet committed
         next_st   = S_DEV;
         next_cnt  = '0;
         next_oe   = 1'b0;
         next_pend = 1'b0;
         next_pval = '0;
      end else if (stop_c) begin
         next_st   = S_IDLE;
         next_oe   = 1'b0;
         next_pend = 1'b0;
         next_pval = '0;
         if (pend && !wp_s) begin
            do_commit = 1'b1;
            next_busy = BW'(PROG_CYCLES);
         end
      end else if (st == S_RD) begin
         // read path never looks at write-protect
         if (scl_rise && cnt < BIT_ACK) begin
            next_cnt = cnt + 4'h1;
         end else if (scl_rise && cnt == BIT_ACK) begin
            if (!sda_s) begin
               next_cnt = BIT_DONE;
            end else begin
               next_st = S_IDLE;
            end
         end else if (scl_fall && cnt == BIT_ACK) begin
            next_oe = 1'b0;
         end else if (scl_fall && cnt == BIT_DONE) begin
            next_sh  = rd_byte;
            next_ptr = ptr + 8'h01;
            next_oe  = !rd_byte[7];
            next_cnt = '0;
         end else if (scl_fall && cnt != 4'h0) begin
            next_sh = {sh[6:0], 1'b0};
            next_oe = !sh[6];
         end
      end else if (st != S_IDLE) begin
         if (scl_rise && cnt < BIT_ACK) begin
            next_sh  = {sh[6:0], sda_s};
            next_cnt = cnt + 4'h1;
         end else if (scl_rise && cnt == BIT_ACK) begin
            next_cnt = BIT_DONE;
         end else if (scl_fall && cnt == BIT_ACK) begin
            case (st)
               S_DEV: begin
                  if (sh[7:4] == TYPE_CODE && sh[3:1] == cs_s && busy == '0) begin
                     next_oe = 1'b1;
                  end else begin
                     next_st = S_IDLE;
                  end
               end
               S_WADR: begin
                  next_oe  = 1'b1;
                  next_ptr = sh;
               end
               default: begin
                  next_oe                = 1'b1;
                  next_pbuf[ptr[3:0]]    = sh;
                  next_pval[ptr[3:0]]    = 1'b1;
                  next_pend              = 1'b1;
                  next_ptr               = {ptr[7:4], ptr[3:0] + 4'h1};
               end
            endcase
         end else if (scl_fall && cnt == BIT_DONE) begin
            next_oe  = 1'b0;
            next_cnt = '0;
            case (st)
               S_DEV: begin
                  if (sh[0]) begin
                     next_st  = S_RD;
                     next_sh  = rd_byte;
                     next_ptr = ptr + 8'h01;
                     next_oe  = !rd_byte[7];
                  end else begin
                     next_st = S_WADR;
                  end
               end
               S_WADR: begin
                  next_st = S_WDAT;
               end
               default: begin
                  next_st = st;
               end
            endcase
         end
      end
   end

   // the whole loaded page lands in one cycle; the busy count models the cell time
   always_comb begin
      next_mem = mem;
      if (do_commit) begin
         for (int j = 0; j < PAGE_BYTES; j++) begin
            if (pval[j]) begin
               next_mem[{ptr[7:4], COL_W'(j)}] = pbuf[j];
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      mem  <= next_mem;
      pbuf <= next_pbuf;
      sh   <= next_sh;
      if (!aresetn) begin
         st   <= S_IDLE;
         cnt  <= '0;
         oe   <= 1'b0;
         ptr  <= PTR_RST;
         pend <= 1'b0;
         pval <= '0;
         busy <= '0;
      end else begin
         st   <= next_st;
         cnt  <= next_cnt;
         oe   <= next_oe;
         ptr  <= next_ptr;
         pend <= next_pend;
         pval <= next_pval;
         busy <= next_busy;
      end
   end

   assign bus.d_sda_o  = 1'b0;
   assign bus.d_sda_oe = oe;
   assign prog_busy    = (busy != '0);
   assign standby      = (st == S_IDLE) && (busy == '0);
endmodule
`default_nettype wire

//--- src/tws_bus_host.sv
// two-wire bus host end driven by software over axi4-lite
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tws_bus_host #(
   parameter int QUARTER = tws_pkg::SCL_QUART
) (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   tws_if.host                             bus,
   input  wire logic [tws_pkg::AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [tws_pkg::AXI_AW-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready
);
   import tws_pkg::*;

   localparam int QW = $clog2(QUARTER) + 1;

   typedef enum logic {H_IDLE, H_RUN} tws_hst_e;

   tws_hst_e           st, next_st;
   logic [2:0]         op, next_op;
   logic [7:0]         tx, next_tx;
   logic [7:0]         rx, next_rx;
   logic               nack, next_nack;
   logic               ack, next_ack;
   logic [3:0]         bitn, next_bitn;
   logic [1:0]         ph, next_ph;
   logic [QW-1:0]      qc, next_qc;
   logic               scl, next_scl;
   logic               sda_lo, next_sda_lo;
   logic [1:0]         sda_q;
   logic               aw_got, next_aw_got;
   logic [AXI_AW-1:0]  aw_a, next_aw_a;
   logic               w_got, next_w_got;
   logic [31:0]        w_d, next_w_d;
   logic [3:0]         w_s, next_w_s;
   logic               bvalid, next_bvalid;
   logic [1:0]         bresp, next_bresp;
   logic               rvalid, next_rvalid;
   logic [31:0]        rdata, next_rdata;
   logic [1:0]         rresp, next_rresp;
   logic [2:0]         cmd_op;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sda_q <= 2'h3;
      end else begin
         sda_q <= {sda_q[0], bus.sda};
      end
   end

   assign s_axi_awready = !aw_got && !bvalid;
   assign s_axi_wready  = !w_got && !bvalid;
   assign s_axi_arready = !rvalid;
   assign cmd_op        = w_d[CMD_OP_LSB +: 3];

   always_comb begin
      next_st     = st;
      next_op     = op;
      next_tx     = tx;
      next_rx     = rx;
      next_nack   = nack;
      next_ack    = ack;
      next_bitn   = bitn;
      next_ph     = ph;
      next_qc     = qc;
      next_scl    = scl;
      next_sda_lo = sda_lo;
      next_aw_got = aw_got;
      next_aw_a   = aw_a;
      next_w_got  = w_got;
      next_w_d    = w_d;
      next_w_s    = w_s;
      next_bvalid = bvalid;
      next_bresp  = bresp;
      next_rvalid = rvalid;
      next_rdata  = rdata;
      next_rresp  = rresp;
      // bit engine: four quarters per bit, data bits move with the clock low, start and stop move sda with it high
      if (st == H_RUN) begin
         if (qc == QW'(QUARTER - 1)) begin
            next_qc = '0;
            next_ph = ph + 2'h1;
            case (ph)
               2'h0: next_scl = 1'b1;
               2'h1: begin
                  if (op == OP_START) begin
                     next_sda_lo = 1'b1;
                  end else if (op == OP_STOP) begin
                     next_sda_lo = 1'b0;
                     next_st     = H_IDLE;
                  end else if (bitn < BIT_ACK) begin
                     next_rx = {rx[6:0], sda_q[1]};
                  end else if (op == OP_WRITE) begin
                     next_ack = !sda_q[1];
                  end
               end
               2'h2: begin
                  next_scl = 1'b0;
                  if (op == OP_START) begin
                     next_st = H_IDLE;
                  end
               end
               default: begin
                  next_bitn = bitn + 4'h1;
                  next_tx   = {tx[6:0], 1'b0};
                  if (bitn == BIT_ACK) begin
                     next_st = H_IDLE;
                  end else if (op == OP_WRITE) begin
                     next_sda_lo = (bitn != 4'h7) && !tx[6];
                  end else begin
                     next_sda_lo = (bitn == 4'h7) && !nack;
                  end
               end
            endcase
         end else begin
            next_qc = qc + 1'b1;
         end
      end
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_got = 1'b1;
         next_aw_a   = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_got = 1'b1;
         next_w_d   = s_axi_wdata;
         next_w_s   = s_axi_wstrb;
      end
      if (aw_got && w_got) begin
         next_aw_got = 1'b0;
         next_w_got  = 1'b0;
         next_bvalid = 1'b1;
         next_bresp  = (aw_a == REG_CMD || aw_a == REG_STAT) ? RESP_OKAY : RESP_SLV;
         // a command while the engine runs is dropped; software polls busy first
         if (aw_a == REG_CMD && w_s[1] && st == H_IDLE &&
             cmd_op >= OP_START && cmd_op <= OP_READ) begin
            next_st     = H_RUN;
            next_op     = cmd_op;
            next_tx     = w_d[CMD_TX_LSB +: 8];
            next_nack   = w_d[CMD_NACK];
            next_bitn   = '0;
            next_ph     = '0;
            next_qc     = '0;
            next_scl    = 1'b0;
            next_sda_lo = (cmd_op == OP_STOP) || (cmd_op == OP_WRITE && !w_d[CMD_TX_LSB + 7]);
         end
      end else if (bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rdata  = '0;
         next_rresp  = (s_axi_araddr == REG_CMD || s_axi_araddr == REG_STAT) ? RESP_OKAY : RESP_SLV;
         if (s_axi_araddr == REG_STAT) begin
            next_rdata[STAT_BUSY]     = (st == H_RUN);
            next_rdata[STAT_ACK]      = ack;
            next_rdata[STAT_RX +: 8]  = rx;
         end
      end else if (rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      tx    <= next_tx;
      rx    <= next_rx;
      aw_a  <= next_aw_a;
      w_d   <= next_w_d;
      w_s   <= next_w_s;
      rdata <= next_rdata;
      if (!aresetn) begin
         st     <= H_IDLE;
         op     <= '0;
         nack   <= 1'b0;
         ack    <= 1'b0;
         bitn   <= '0;
         ph     <= '0;
         qc     <= '0;
         scl    <= 1'b1;
         sda_lo <= 1'b0;
         aw_got <= 1'b0;
         w_got  <= 1'b0;
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
         rvalid <= 1'b0;
         rresp  <= RESP_OKAY;
      end else begin
         st     <= next_st;
         op     <= next_op;
         nack   <= next_nack;
         ack    <= next_ack;
         bitn   <= next_bitn;
         ph     <= next_ph;
         qc     <= next_qc;
         scl    <= next_scl;
         sda_lo <= next_sda_lo;
         aw_got <= next_aw_got;
         w_got  <= next_w_got;
         bvalid <= next_bvalid;
         bresp  <= next_bresp;
         rvalid <= next_rvalid;
         rresp  <= next_rresp;
      end
   end

   assign bus.scl      = scl;
   assign bus.m_sda_o  = 1'b0;
   assign bus.m_sda_oe = sda_lo;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp  = bresp;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rdata  = rdata;
   assign s_axi_rresp  = rresp;
endmodule
`default_nettype wire

//--- tb/tws_chk.sv
// concurrent checks on the two-wire bus and the device status outputs
`timescale 1ns/1ps
`default_nettype none
module tws_chk #(
   parameter int PROG_CYCLES = tws_pkg::PROG_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic scl,
   input wire logic sda,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   input wire logic d_sda_o,
   input wire logic d_sda_oe,
   input wire logic write_protect,
   input wire logic standby,
   input wire logic prog_busy
);
   int busy_n;
   int next_busy_n;
   // counts busy cycles so the full programming span is judged at its end
   always_comb next_busy_n = prog_busy ? busy_n + 1 : 0;
   always_ff @(posedge aclk) busy_n <= aresetn ? next_busy_n : 0;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_dev_open_drain: assert property (d_sda_oe |-> !d_sda_o) else $error("device drove sda high");
   chk_host_open_drain: assert property (m_sda_oe |-> !m_sda_o) else $error("host drove sda high");
   chk_ack_pulls_low: assert property (d_sda_oe |-> !sda) else $error("driven sda not low");
   chk_dev_shift_low: assert property ($changed(d_sda_oe) |-> !scl) else $error("sda moved, scl high");
   chk_busy_silent: assert property (prog_busy |-> !d_sda_oe && !standby) else $error("busy but active");
   chk_standby_quiet: assert property (standby |-> !d_sda_oe) else $error("sda driven in standby");
   chk_prog_length: assert property ($fell(prog_busy) |-> busy_n == PROG_CYCLES) else $error("bad prog span");
   chk_wp_no_prog: assert property (write_protect && $past(write_protect, 3) |-> !$rose(prog_busy))
      else $error("programmed while protected");
   // a start from idle holds the clock low for one quarter only, so five low samples is the floor
   chk_scl_low_hold: assert property ($fell(scl) |=> !scl [*4]) else $error("scl low phase short");
   cover property ($rose(prog_busy));
   cover property ($rose(d_sda_oe));
   cover property ($fell(standby));
endmodule
`default_nettype wire

//--- tb/test_two_wire_eeprom_slave_interface.sv
// bench: axi4-lite orders drive the host end against the eeprom end
`timescale 1ns/1ps
`default_nettype none
module test_two_wire_eeprom_slave_interface;
   import tws_pkg::*;
   localparam int         PROG = 400;
   localparam logic [2:0] CS   = 3'h5;
   localparam logic [7:0] DW   = {TYPE_CODE, CS, 1'b0};
   localparam logic [7:0] DR   = {TYPE_CODE, CS, 1'b1};
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic [2:0]  cs = CS;
   logic        wp = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, standby, prog_busy;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   int          failures = 0;
   int          check_count = 0;
   tws_if bus_if ();
   tws_bus_host tws_bus_host_inst (
      .aclk(aclk), .aresetn(aresetn), .bus(bus_if),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   tws_eeprom_dev #(.PROG_CYCLES(PROG)) tws_eeprom_dev_inst (
      .aclk(aclk), .aresetn(aresetn), .bus(bus_if), .chip_select_bit_high(cs[2]),
      .chip_select_bit_mid(cs[1]), .chip_select_bit_low(cs[0]), .write_protect(wp),
      .standby(standby), .prog_busy(prog_busy));
   tws_chk #(.PROG_CYCLES(PROG)) tws_chk_inst (
      .aclk(aclk), .aresetn(aresetn), .scl(bus_if.scl), .sda(bus_if.sda), .m_sda_o(bus_if.m_sda_o),
      .m_sda_oe(bus_if.m_sda_oe), .d_sda_o(bus_if.d_sda_o), .d_sda_oe(bus_if.d_sda_oe),
      .write_protect(wp), .standby(standby), .prog_busy(prog_busy));
   always #12.5 aclk = ~aclk;
   task automatic chk(input logic ok, input string m);
      check_count++;
      if (ok !== 1'b1) begin
         failures++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task automatic test_done();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask
   // one bus operation, then wait for the host engine to finish it
   task automatic op(input logic [2:0] c, input logic [7:0] tx, input logic nk, output logic [31:0] st);
      logic [1:0] r;
      axi_wr(REG_CMD, {20'h0_0000, nk, c, tx}, r);
      do axi_rd(REG_STAT, st, r); while (st[STAT_BUSY] !== 1'b0);
   endtask
   task automatic cond(input logic [2:0] c);
      logic [31:0] st;
      op(c, 8'h00, 1'b0, st);
   endtask
   task automatic send(input logic [7:0] b, input logic a);
      logic [31:0] st;
      op(OP_WRITE, b, 1'b0, st);
      chk(st[STAT_ACK] === a, "acknowledge");
   endtask
   task automatic rd(input logic nk, output logic [7:0] b);
      logic [31:0] st;
      op(OP_READ, 8'h00, nk, st);
      b = st[STAT_RX+:8];
   endtask
   task automatic seek(input logic [7:0] a);
      cond(OP_START);
      send(DW, 1'b1);
      send(a, 1'b1);
      cond(OP_START);
      send(DR, 1'b1);
   endtask
   task automatic idle_chk();
      for (int i = 0; i < 20 && standby !== 1'b1; i++) @(posedge aclk);
      chk(standby === 1'b1 && prog_busy === 1'b0, "not in standby");
   endtask
   task automatic wait_prog(input logic poll);
      for (int i = 0; i < 20 && prog_busy !== 1'b1; i++) @(posedge aclk);
      chk(prog_busy === 1'b1, "programming missing");
      if (poll) begin
         cond(OP_START);
         send(DW, 1'b0);
         cond(OP_STOP);
      end
      while (prog_busy !== 1'b0) @(posedge aclk);
      idle_chk();
   endtask
   task automatic sc_idle();
      logic [31:0] d;
      logic [1:0]  r;
      chk(standby === 1'b1 && bus_if.sda === 1'b1 && bus_if.scl === 1'b1, "not idle");
      axi_rd(8'h40, d, r);
      chk(r === RESP_SLV, "unmapped read");
      axi_wr(8'h40, 32'h0000_0000, r);
      chk(r === RESP_SLV, "unmapped write");
   endtask
   task automatic sc_byte();
      logic [7:0] d;
      cond(OP_START);
      send(DW, 1'b1);
      send(8'h00, 1'b1);
      send(8'h5a, 1'b1);
      cond(OP_STOP);
      wait_prog(1'b1);
      seek(8'h00);
      rd(1'b1, d);
      chk(d === 8'h5a, "byte readback");
      cond(OP_STOP);
      idle_chk();
   endtask
   // seventeen bytes: the last folds onto the first column; reading on wraps to zero
   task automatic sc_page();
      logic [7:0] d;
      cond(OP_START);
      send(DW, 1'b1);
      send(8'hf0, 1'b1);
      for (int k = 0; k < 17; k++) send(8'h80 + k[7:0], 1'b1);
      cond(OP_STOP);
      wait_prog(1'b0);
      seek(8'hf0);
      for (int k = 0; k < 17; k++) begin
         rd(k == 16, d);
         chk(d === (k == 0 ? 8'h90 : k == 16 ? 8'h5a : 8'h80 + k[7:0]), "page data");
      end
      cond(OP_STOP);
   endtask
   task automatic sc_protect();
      logic [7:0] d;
      @(posedge aclk);
      wp <= 1'b1;
      cond(OP_START);
      send(DW, 1'b1);
      send(8'h00, 1'b1);
      send(8'ha5, 1'b1);
      cond(OP_STOP);
      idle_chk();
      seek(8'h00);
      rd(1'b1, d);
      chk(d === 8'h5a, "protected data changed");
      cond(OP_STOP);
      @(posedge aclk);
      wp <= 1'b0;
   endtask
   task automatic sc_select();
      logic [7:0] d;
      cond(OP_START);
      send({4'hb, CS, 1'b0}, 1'b0);
      cond(OP_START);
      send({TYPE_CODE, 3'h4, 1'b0}, 1'b0);
      cond(OP_STOP);
      idle_chk();
      @(posedge aclk);
      cs <= 3'h0;
      cond(OP_START);
      send({TYPE_CODE, 3'h0, 1'b0}, 1'b1);
      send(8'hf5, 1'b1);
      cond(OP_START);
      send({TYPE_CODE, 3'h0, 1'b1}, 1'b1);
      rd(1'b1, d);
      chk(d === 8'h85, "select readback");
      cond(OP_STOP);
      idle_chk();
      @(posedge aclk);
      cs <= CS;
   endtask
   task automatic sc_soft();
      cond(OP_START);
      send(DW, 1'b1);
      cond(OP_START);
      send(8'hff, 1'b0);
      send(8'hff, 1'b0);
      cond(OP_START);
      send(DW, 1'b1);
      cond(OP_STOP);
      idle_chk();
   endtask
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      sc_idle();
      sc_byte();
      sc_page();
      sc_protect();
      sc_select();
      sc_soft();
      test_done();
   end
   initial begin
      repeat (90000) @(posedge aclk);
      failures++;
      $display("unexpected at %0t: watchdog expired", $time);
      test_done();
   end
endmodule
`default_nettype wire
